// >>> rtl/stpm_timer.sv
// standard 16-bit timer: compare, timer/counter, pwm and single-pulse modes
// assumes a timer-clock tick input and synchronous control levels
// Function
// - mode 11 counts like compare mode, pin untouched
// - pwm ignores clear-source, one register sets period
// - swap bit chooses period and duty registers
// - swap clear: period p times 256, 0 wraps
// - duty at or above period gives 100%
// - swap set: a is period, p*256 duty
// - pwm raises a flag per comparator match
// - level bit, pin-function and invert shape output
// - pwm keeps counting while pin forced
// - period clear starts new pwm period
// - run rising edge starts pulse and counter
// - trigger pin edge sets run bit in single-pulse mode
// - run clear or a match ends pulse
// - single-pulse a match raises flag
// - single-pulse resets counter only on run rise
// - compare mode pin changes only on an a match or run rise
// - clear-source 1: a clears, no p flag
// - swap 0 p period a duty, 1 reversed
// - p value compares counter bits 15..8
// - level bit applied when run bit rises
`timescale 1ns/10ps
`default_nettype none
`include "stpm_consts.svh"
module stpm_timer
#(
  parameter int CNT_W  = `STPM_CNT_W,
  parameter int COMPARE_P_VALUE_W = `STPM_COMPARE_P_VALUE_W
)
(
  // clock, reset, enable
  input  wire logic                 CLK_SYS_I,
  input  wire logic                 RST_I,
  input  wire logic                 CE_I,
  // timer clock and pause
  input  wire logic                 TICK_I,
  input  wire logic                 PAUSE_I,
  // control
  input  wire stpm_pkg::stpm_mode_t  MODE_SELECT_I,
  input  wire stpm_pkg::stpm_pinfn_t PIN_FUNCTION_BITS_I,
  input  wire logic                 OUTPUT_LEVEL_CTRL_I,
  input  wire logic                 OUTPUT_INVERT_I,
  input  wire logic                 DUTY_PERIOD_SWAP_I,
  input  wire logic                 CLEAR_SOURCE_SELECT_I,
  input  wire logic                 RUN_SET_I,
  input  wire logic                 RUN_CLR_I,
  input  wire logic [CNT_W-1:0]     COMPARE_A_VALUE_I,
  input  wire logic [COMPARE_P_VALUE_W-1:0]    COMPARE_P_VALUE_I,
  // external trigger
  input  wire logic                 EXT_TRIGGER_PIN_I,
  input  wire logic                 TRIG_FALL_SEL_I,
  // flag clears
  input  wire logic                 MATCH_A_CLR_I,
  input  wire logic                 MATCH_P_CLR_I,
  // status
  output logic                      COUNTER_RUN_O,
  output logic [CNT_W-1:0]          COUNT_O,
  output logic                      MATCH_A_FLAG_O,
  output logic                      MATCH_P_FLAG_O,
  // pin
  output logic                      TIMER_PIN_O,
  output logic                      TIMER_PIN_OE_O
);
  import stpm_pkg::*;

  initial
  begin
    if (CNT_W != 16 || COMPARE_P_VALUE_W != 8)
      $error("stpm_timer supports only a 16-bit counter with 8-bit p compare");
  end

  logic             run_q;
  logic [CNT_W-1:0] cnt;
  logic             lvl;
  logic             trig_edge;
  logic             run_rise;
  logic             next_run;
  logic             step;
  logic             hit_a;
  logic             hit_p;
  logic             ovf;
  logic             clr_cnt;
  logic             duty_hit;
  logic [CNT_W:0]   period_len;
  logic [CNT_W:0]   duty_len;
  stpm_op_e         op;

  function automatic logic [CNT_W:0] p_span(input logic [COMPARE_P_VALUE_W-1:0] p);
    // zero stands for the full 16-bit wrap
    p_span = (p == '0) ? {1'b1, {CNT_W{1'b0}}} : {1'b0, p, 8'h00};
  endfunction

  function automatic logic [CNT_W:0] a_span(input logic [CNT_W-1:0] a);
    a_span = (a == '0) ? {1'b1, {CNT_W{1'b0}}} : {1'b0, a};
  endfunction

  stpm_edge u_trig
  (
    .clk_i      (CLK_SYS_I),
    .rst_i      (RST_I),
    .ce_i       (CE_I),
    .d_i        (EXT_TRIGGER_PIN_I),
    .fall_sel_i (TRIG_FALL_SEL_I),
    .edge_o     (trig_edge)
  );

  always_comb
  begin
    case (MODE_SELECT_I)
      `STPM_MODE_PWM:
        op = (PIN_FUNCTION_BITS_I == `STPM_PF_PULSE) ? STPM_ST_PULSE : STPM_ST_PWM;
      `STPM_MODE_TMR:
        op = STPM_ST_TMR;
      default:
        op = STPM_ST_CMP;
    endcase
  end

  // matches are judged on the tick that moves the counter onto the compare value
  assign step  = CE_I & TICK_I & run_q & ~PAUSE_I;
  assign hit_a = step & (cnt + 16'h0001 == COMPARE_A_VALUE_I) & (COMPARE_A_VALUE_I != '0);
  assign hit_p = step & (cnt[CNT_W-1:8] + 8'h01 == COMPARE_P_VALUE_I) & (cnt[7:0] == 8'hff)
               & (COMPARE_P_VALUE_I != '0);
  assign ovf   = step & (cnt == '1);

  assign period_len = DUTY_PERIOD_SWAP_I ? a_span(COMPARE_A_VALUE_I)
                                         : p_span(COMPARE_P_VALUE_I);
  assign duty_len   = DUTY_PERIOD_SWAP_I ? p_span(COMPARE_P_VALUE_I)
                                         : {1'b0, COMPARE_A_VALUE_I};

  always_comb
  begin
    case (op)
      STPM_ST_PWM:
        // period comparator only; clear-source is ignored
        clr_cnt = DUTY_PERIOD_SWAP_I ? (hit_a | ovf) : (hit_p | ovf);
      STPM_ST_PULSE:
        clr_cnt = 1'b0;
      default:
        clr_cnt = CLEAR_SOURCE_SELECT_I ? hit_a : (hit_p | ovf);
    endcase
  end

  // run bit: set wins over clear; trigger pin only arms it in single-pulse mode
  always_comb
  begin
    next_run = run_q;
    if (RUN_CLR_I)
      next_run = 1'b0;
    if (op == STPM_ST_PULSE && hit_a)
      next_run = 1'b0;
    if (RUN_SET_I)
      next_run = 1'b1;
    if (op == STPM_ST_PULSE && trig_edge)
      next_run = 1'b1;
  end

  assign run_rise = next_run & ~run_q;

  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
      run_q <= 1'b0;
    else if (CE_I)
      run_q <= next_run;
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
      cnt <= `STPM_CNT_RST;
    else if (CE_I)
    begin
      if (run_rise)
        cnt <= '0;
      else if (step)
        cnt <= clr_cnt ? '0 : cnt + 16'h0001;
    end
  end

  // duty match position: count+1 reaches duty length
  assign duty_hit = step & ({1'b0, cnt} + 17'h00001 == duty_len);

  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
    begin
      MATCH_A_FLAG_O <= 1'b0;
      MATCH_P_FLAG_O <= 1'b0;
    end
    else if (CE_I)
    begin
      if (hit_a)
        MATCH_A_FLAG_O <= 1'b1;
      else if (MATCH_A_CLR_I)
        MATCH_A_FLAG_O <= 1'b0;
      if (hit_p && !(op != STPM_ST_PWM && CLEAR_SOURCE_SELECT_I) && op != STPM_ST_PULSE)
        MATCH_P_FLAG_O <= 1'b1;
      else if (MATCH_P_CLR_I)
        MATCH_P_FLAG_O <= 1'b0;
    end
  end

  // lvl is the un-inverted pin level before the invert stage
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
      lvl <= `STPM_PIN_RST;
    else if (CE_I)
    begin
      case (op)
        STPM_ST_CMP:
        begin
          if (run_rise)
            lvl <= OUTPUT_LEVEL_CTRL_I;
          else if (hit_a)
          begin
            case (PIN_FUNCTION_BITS_I)
              2'h1:    lvl <= 1'b0;
              2'h2:    lvl <= 1'b1;
              2'h3:    lvl <= ~lvl;
              default: lvl <= lvl;
            endcase
          end
        end
        STPM_ST_PWM:
        begin
          // duty >= period keeps active all period
          if (run_rise || clr_cnt)
            lvl <= OUTPUT_LEVEL_CTRL_I;
          else if (duty_hit && duty_len < period_len)
            lvl <= ~OUTPUT_LEVEL_CTRL_I;
        end
        STPM_ST_PULSE:
        begin
          if (run_rise)
            lvl <= OUTPUT_LEVEL_CTRL_I;
          else if (run_q && !next_run)
            lvl <= ~OUTPUT_LEVEL_CTRL_I;
        end
        default:
          lvl <= lvl;
      endcase
    end
  end

  // pwm forced levels override the waveform but not the counting
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
    begin
      TIMER_PIN_O    <= `STPM_PIN_RST;
      TIMER_PIN_OE_O <= 1'b0;
    end
    else if (CE_I)
    begin
      TIMER_PIN_OE_O <= (op != STPM_ST_TMR);
      if (op == STPM_ST_PWM && PIN_FUNCTION_BITS_I == `STPM_PF_INACT)
        TIMER_PIN_O <= ~OUTPUT_LEVEL_CTRL_I ^ OUTPUT_INVERT_I;
      else if (op == STPM_ST_PWM && PIN_FUNCTION_BITS_I == `STPM_PF_ACT)
        TIMER_PIN_O <= OUTPUT_LEVEL_CTRL_I ^ OUTPUT_INVERT_I;
      else if (op == STPM_ST_TMR)
        TIMER_PIN_O <= 1'b0;
      else
        TIMER_PIN_O <= next_lvl_view() ^ OUTPUT_INVERT_I;
    end
  end

  // pin follows the level register one cycle later; simple registered view
  function automatic logic next_lvl_view();
    next_lvl_view = lvl;
  endfunction

  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
    begin
      COUNT_O       <= `STPM_CNT_RST;
      COUNTER_RUN_O <= 1'b0;
    end
    else if (CE_I)
    begin
      COUNT_O       <= cnt;
      COUNTER_RUN_O <= run_q;
    end
  end
  // are software's duty; mode decode relies on them
endmodule
`default_nettype wire

// >>> rtl/stpm_consts.svh
// constants for the standard timer: mode codes, pin-function codes, widths
// assumes inclusion by bare name from rtl/ files
`ifndef STPM_CONSTS_SVH
`define STPM_CONSTS_SVH
`define STPM_CNT_W        16
`define STPM_COMPARE_P_VALUE_W       8
`define STPM_MODE_CMP     2'h0
`define STPM_MODE_UNDEF   2'h1
`define STPM_MODE_PWM     2'h2
`define STPM_MODE_TMR     2'h3
`define STPM_PF_INACT     2'h0
`define STPM_PF_ACT       2'h1
`define STPM_PF_PWM       2'h2
`define STPM_PF_PULSE     2'h3
`define STPM_CNT_RST      16'h0000
`define STPM_PIN_RST      1'h0
`endif

// >>> rtl/stpm_pkg.sv
// types for the standard timer
// assumes stpm_consts.svh is on the include path
`include "stpm_consts.svh"
package stpm_pkg;
  typedef logic [1:0] stpm_mode_t;
  typedef logic [1:0] stpm_pinfn_t;
  typedef enum logic [1:0] {
    STPM_ST_CMP   = 2'b00,
    STPM_ST_PWM   = 2'b01,
    STPM_ST_PULSE = 2'b10,
    STPM_ST_TMR   = 2'b11
  } stpm_op_e;
endpackage

// >>> rtl/stpm_edge.sv
// rising/falling edge detector for the external trigger pin
// assumes the pin is synchronous to the clock
`timescale 1ns/10ps
`default_nettype none
module stpm_edge
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  // sample
  input  wire logic d_i,
  input  wire logic fall_sel_i,
  output logic      edge_o
);
  logic prev;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prev <= 1'b0;
    else if (ce_i)
      prev <= d_i;
  end

  // active edge selectable so the same block serves both trigger senses
  assign edge_o = ce_i & (fall_sel_i ? (prev & ~d_i) : (~prev & d_i));
endmodule
`default_nettype wire

// >>> verif/stpm_timer_chk.sv
// checker for the timer run bit, count, match-a flag and pin
// assumes CE_I high and TRIG_FALL_SEL_I low
`timescale 1ns/10ps
`default_nettype none
module stpm_timer_chk
#(
  parameter int CNT_W = 16
)
(
  // watched ports
  input wire logic                  CLK_SYS_I,
  input wire logic                  RST_I,
  input wire logic                  TICK_I,
  input wire stpm_pkg::stpm_mode_t  MODE_SELECT_I,
  input wire stpm_pkg::stpm_pinfn_t PIN_FUNCTION_BITS_I,
  input wire logic                  OUTPUT_LEVEL_CTRL_I,
  input wire logic                  OUTPUT_INVERT_I,
  input wire logic                  EXT_TRIGGER_PIN_I,
  input wire logic                  MATCH_A_CLR_I,
  input wire logic                  COUNTER_RUN_O,
  input wire logic [CNT_W-1:0]      COUNT_O,
  input wire logic                  MATCH_A_FLAG_O,
  input wire logic                  TIMER_PIN_O,
  input wire logic                  TIMER_PIN_OE_O
);
  import stpm_pkg::*;
  wire logic pls = MODE_SELECT_I == 2'h2 && PIN_FUNCTION_BITS_I == 2'h3;
  wire logic act = OUTPUT_LEVEL_CTRL_I ^ OUTPUT_INVERT_I;
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);
  sequence pls_up;
    pls && $rose(COUNTER_RUN_O);
  endsequence
  sequence pls_down;
    pls && $fell(COUNTER_RUN_O);
  endsequence
  tmr_pin_off_a: assert property (MODE_SELECT_I == 2'h3 [*2] |=> !TIMER_PIN_OE_O)
    else $error("pin driven in timer mode");
  flag_hold_a: assert property (MATCH_A_FLAG_O && !MATCH_A_CLR_I |=> MATCH_A_FLAG_O)
    else $error("flag dropped");
  count_step_a: assert property ($changed(COUNT_O) && COUNT_O != '0 |->
    $past(TICK_I, 2) && COUNT_O == $past(COUNT_O) + 1'b1)
    else $error("bad count step");
  match_stop_a: assert property ($rose(MATCH_A_FLAG_O) && pls |-> ##[0:2] !COUNTER_RUN_O)
    else $error("run kept after match");
  lead_level_a: assert property (pls_up |-> ##[0:2] TIMER_PIN_O == act)
    else $error("no leading edge");
  trail_level_a: assert property (pls_down |-> ##[0:2] TIMER_PIN_O != act)
    else $error("no trailing edge");
  trig_start_a: assert property (pls && $rose(EXT_TRIGGER_PIN_I) && !COUNTER_RUN_O
    |-> ##[1:4] COUNTER_RUN_O)
    else $error("trigger ignored");
  forced_act_a: assert property ((MODE_SELECT_I == 2'h2 && PIN_FUNCTION_BITS_I == 2'h1
    && COUNTER_RUN_O) [*3] |-> TIMER_PIN_O == act)
    else $error("forced level wrong");
endmodule
bind stpm_timer stpm_timer_chk #(.CNT_W(CNT_W)) u_stpm_timer_chk (.CLK_SYS_I, .RST_I,
  .TICK_I, .MODE_SELECT_I, .PIN_FUNCTION_BITS_I, .OUTPUT_LEVEL_CTRL_I, .OUTPUT_INVERT_I,
  .EXT_TRIGGER_PIN_I, .MATCH_A_CLR_I, .COUNTER_RUN_O, .COUNT_O, .MATCH_A_FLAG_O,
  .TIMER_PIN_O, .TIMER_PIN_OE_O);
`default_nettype wire

// >>> verif/stpm_far.sv
// far side: trigger source and a load timing one active pulse
// assumes the pin settles within a clock
`timescale 1ns/10ps
`default_nettype none
module stpm_far
(
  // requests
  input  wire logic        clk_i,
  input  wire logic        trig_i,
  input  wire logic        arm_i,
  input  wire logic        act_i,
  // pins and result
  input  wire logic        pin_i,
  output var  logic        trig_pin_o,
  output var  logic        done_o,
  output var  logic [16:0] width_o
);
  logic armed = 1'b0;
  logic seen = 1'b0;
  initial
  begin
    trig_pin_o = 1'b0;
    done_o = 1'b0;
    width_o = 17'h0;
  end
  always @(posedge clk_i)
  begin
    trig_pin_o <= trig_i;
    done_o <= 1'b0;
    if (arm_i)
    begin
      armed <= 1'b1;
      seen <= 1'b0;
      width_o <= 17'h0;
    end
    else if (armed && pin_i === act_i)
    begin
      seen <= 1'b1;
      width_o <= width_o + 17'h1;
    end
    else if (armed && seen)
    begin
      armed <= 1'b0;
      done_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// bench for the timer: timer, compare, pwm and single pulse
// assumes one tick a clock unless ticks are randomised
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import stpm_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, tk = 1'b1, olc = 1'b1, inv = 1'b0, swp = 1'b0;
  logic        css = 1'b0, rs = 1'b0, rc = 1'b0, ca = 1'b0, cp = 1'b0, tr = 1'b0, arm = 1'b0;
  stpm_mode_t  md = 2'h3;
  stpm_pinfn_t pf = 2'h0;
  logic [15:0] av = 16'h0, cnt;
  logic [7:0]  pv = 8'h0;
  logic        run, fa, fp, pin, oe, tpin, done;
  logic [16:0] wid, ew, exp_q[$];
  int          bad_count = 0, check_count = 0, n, r;
  always #2 clk = ~clk;
  stpm_timer u_stpm_timer (.CLK_SYS_I(clk), .RST_I(rst), .CE_I(1'b1), .TICK_I(tk),
    .PAUSE_I(1'b0), .MODE_SELECT_I(md), .PIN_FUNCTION_BITS_I(pf), .OUTPUT_LEVEL_CTRL_I(olc),
    .OUTPUT_INVERT_I(inv), .DUTY_PERIOD_SWAP_I(swp), .CLEAR_SOURCE_SELECT_I(css),
    .RUN_SET_I(rs), .RUN_CLR_I(rc), .COMPARE_A_VALUE_I(av), .COMPARE_P_VALUE_I(pv),
    .EXT_TRIGGER_PIN_I(tpin), .TRIG_FALL_SEL_I(1'b0), .MATCH_A_CLR_I(ca), .MATCH_P_CLR_I(cp),
    .COUNTER_RUN_O(run), .COUNT_O(cnt), .MATCH_A_FLAG_O(fa), .MATCH_P_FLAG_O(fp),
    .TIMER_PIN_O(pin), .TIMER_PIN_OE_O(oe));
  stpm_far u_stpm_far (.clk_i(clk), .trig_i(tr), .arm_i(arm), .act_i(olc ^ inv),
    .pin_i(pin), .trig_pin_o(tpin), .done_o(done), .width_o(wid));
  task automatic chk(input string s, input logic [16:0] e, input logic [16:0] v);
    check_count++;
    if (v !== e)
    begin
      bad_count++;
      $display("[ERR] %s exp %0d seen %0d", s, e, v);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic sw(input logic on);
    rs <= on;
    rc <= !on;
    @(posedge clk);
    rs <= 1'b0;
    rc <= 1'b0;
  endtask
  task automatic clr(input logic s);
    ca <= !s;
    cp <= s;
    @(posedge clk);
    ca <= 1'b0;
    cp <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wf(input logic s);
    n = 0;
    while ((s ? fp : fa) !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  // stale sticky flags would fake a period, so each wait starts from a fresh clear
  task automatic per(input logic s, input int e);
    clr(s);
    wf(s);
    clr(s);
    wf(s);
    chk("period", 17'(e), 17'(n + 2));
  endtask
  task automatic note(input int e);
    exp_q.push_back(17'(e));
    arm <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
  endtask
  task automatic drain;
    n = 0;
    while (exp_q.size() != 0 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    chk("left", 17'h0, 17'(exp_q.size()));
  endtask
  task automatic cfg(input logic [1:0] m, f, input logic [15:0] a, input logic [7:0] p,
                     input logic s);
    sw(1'b0);
    md <= m;
    pf <= f;
    av <= a;
    pv <= p;
    swp <= s;
    tk <= 1'b1;
    clr(1'b0);
    clr(1'b1);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk)
    if (done === 1'b1)
    begin
      ew = exp_q.pop_front();
      chk("width", ew, wid);
    end
  initial
  begin
    #100000;
    bad_count++;
    wrap_up();
  end
  initial
  begin
    void'($urandom(32771));
    cyc(20);
    rst <= 1'b0;
    chk("count", 17'h0, 17'(cnt));
    sw(1'b1);
    r = 0;
    repeat (200)
    begin
      tk <= 1'($urandom_range(1));
      @(posedge clk);
      r += tk;
    end
    tk <= 1'b0;
    sw(1'b0);
    cyc(3);
    chk("count", 17'(r), 17'(cnt));
    chk("oe", 17'h0, 17'(oe));
    css <= 1'b1;
    // p below a so the p comparator is passed each period and a stray p flag would show
    cfg(2'h0, 2'h3, 16'h0200, 8'h01, 1'b0);
    sw(1'b1);
    per(1'b0, 512);
    chk("pflag", 17'h0, 17'(fp));
    cfg(2'h2, 2'h2, 16'h0080, 8'h01, 1'b0);
    sw(1'b1);
    per(1'b1, 256);
    clr(1'b0);
    wf(1'b0);
    cyc(4);
    note(128);
    drain();
    cfg(2'h2, 2'h1, 16'h0080, 8'h01, 1'b0);
    sw(1'b1);
    per(1'b1, 256);
    cfg(2'h2, 2'h2, 16'h0100, 8'h01, 1'b0);
    sw(1'b1);
    cyc(8);
    r = 0;
    repeat (600)
    begin
      @(posedge clk);
      r += (pin !== (olc ^ inv));
    end
    chk("idle", 17'h0, 17'(r));
    cfg(2'h2, 2'h2, 16'h012c, 8'h01, 1'b1);
    sw(1'b1);
    per(1'b0, 300);
    clr(1'b1);
    wf(1'b1);
    cyc(4);
    note(256);
    drain();
    r = 20 + $urandom_range(39);
    cfg(2'h2, 2'h3, 16'(r), 8'h00, 1'b0);
    inv <= 1'b1;
    // a short software pulse leaves the pin inactive, whatever pwm left behind
    sw(1'b1);
    cyc(1);
    sw(1'b0);
    cyc(3);
    note(r);
    tr <= 1'b1;
    cyc(3);
    tr <= 1'b0;
    drain();
    chk("aflag", 17'h1, 17'(fa));
    chk("run", 17'h0, 17'(run));
    cfg(2'h2, 2'h3, 16'h03e8, 8'h00, 1'b0);
    note(30);
    sw(1'b1);
    cyc(29);
    sw(1'b0);
    drain();
    wrap_up();
  end
endmodule
`default_nettype wire
